//--- swdt_pkg.sv
// Constants, register map and carrier types of the system watchdog timer
package swdt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [15:0] CTRL_OFFSET   = 16'h4004;
  localparam logic [15:0] SECURE_OFFSET = 16'h4008;
  localparam logic [15:0] UNLOCK_KEY    = 16'h9716;
  localparam logic [15:0] CTRL_RESET    = 16'hA217;

  localparam int RUN_BIT       = 15;
  localparam int PAUSE_BIT     = 14;
  localparam int SRC_BIT       = 13;
  localparam int SLEEP_RUN_BIT = 12;
  localparam int SW_REFR_BIT   = 11;
  localparam int SECOND_LSB    = 8;
  localparam int FIRST_LSB     = 4;
  localparam int PERIOD_LSB    = 0;

  ////////////////////////////////////////////////////////////////////////////
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_TIME_US   = 1000;
  localparam int TICK_CYCLES    = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int BASE_PERIOD_MS = 256;
  localparam int BASE_TICKS     = BASE_PERIOD_MS * 1000 / TICK_TIME_US;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    ACT_NONE  = 2'h0,
    ACT_IRQ   = 2'h1,
    ACT_RESET = 2'h2,
    ACT_WAKE  = 2'h3
  } swdt_action_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_FIRST  = 4'h2,
    ST_SECOND = 4'h4,
    ST_DONE   = 4'h8
  } swdt_state_t;

  typedef struct packed {
    logic         wdRun;
    logic         wdPause;
    logic         wdRefreshSource;
    logic         wdSleepRun;
    swdt_action_t wdSecondAction;
    swdt_action_t wdFirstAction;
    logic [2:0]   wdPeriodSel;
  } swdt_ctrl_t;

  typedef struct packed {
    logic irq;
    logic devReset;
    logic wake;
  } swdt_act_t;

endpackage

//--- swdt_top.sv
// System watchdog timer with APB register slave
//
// Notes on behaviour
// - The run bit starts or stops the timer, and setting it does not restart the count.
// - The pause bit freezes the count at its present value until it is cleared.
// - Software refresh restarts the timer only when the source bit selects software.
// - In sleep the timer stops unless the sleep-run bit lets it follow the run bit.
// - One period without refresh fires the first action; the period is 0.256 s << code.
// - Two periods without refresh fire the second action, coded none/irq/reset/wake.
// - Writes to all fields except the software refresh bit need the key unlocked.
module swdt_top
#(
  parameter int TICK_CYCLES = swdt_pkg::TICK_CYCLES
)
(
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [15:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                hwRefresh,
  input  wire logic                sleepState,
  output swdt_pkg::swdt_act_t      actOut,
  output swdt_pkg::swdt_state_t    stateOut
);
  import swdt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  swdt_ctrl_t     ctrl_r;
  logic           unlocked_r;
  swdt_state_t    state_r;
  logic [15:0]    cnt_r;
  logic [31:0]    pre_r;
  logic           hwMeta_r;
  logic           hwSync_r;
  logic           hwDly_r;
  logic           hitCtrl;
  logic           hitSecure;
  logic           wrAccess;
  logic           swRefreshHit;
  logic           hwEdge;
  logic           refreshNow;
  logic           active;
  logic           tick;
  logic           step;
  logic           expire;
  logic [15:0]    periodTicks;
  logic [15:0]    ctrlRead;

  ////////////////////////////////////////////////////////////////////////////
  assign hitCtrl   = (paddr == CTRL_OFFSET);
  assign hitSecure = (paddr == SECURE_OFFSET);
  assign wrAccess  = psel && penable && pwrite;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !(hitCtrl || hitSecure);

  assign ctrlRead = {ctrl_r.wdRun, ctrl_r.wdPause, ctrl_r.wdRefreshSource,
                     ctrl_r.wdSleepRun, 2'h0, ctrl_r.wdSecondAction, 2'h0,
                     ctrl_r.wdFirstAction, 1'h0, ctrl_r.wdPeriodSel};

  // Read data captured in setup so it leaves a flip-flop in the access phase
  always_ff @(posedge clock)
  begin
    if (reset)
      prdata <= 32'h0;
    else if (psel && !penable)
      prdata <= hitCtrl ? {16'h0, ctrlRead} :
                hitSecure ? {31'h0, unlocked_r} : 32'h0;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      unlocked_r <= 1'b0;
    else if (wrAccess && hitSecure)
      unlocked_r <= (pwdata[15:0] == UNLOCK_KEY);
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      ctrl_r <= swdt_ctrl_t'({CTRL_RESET[15:12], CTRL_RESET[9:8],
                              CTRL_RESET[5:4], CTRL_RESET[2:0]});
    else if (wrAccess && hitCtrl && unlocked_r)
    begin
      ctrl_r.wdRun           <= pwdata[RUN_BIT];
      ctrl_r.wdPause         <= pwdata[PAUSE_BIT];
      ctrl_r.wdRefreshSource <= pwdata[SRC_BIT];
      ctrl_r.wdSleepRun      <= pwdata[SLEEP_RUN_BIT];
      ctrl_r.wdSecondAction  <= swdt_action_t'(pwdata[SECOND_LSB +: 2]);
      ctrl_r.wdFirstAction   <= swdt_action_t'(pwdata[FIRST_LSB +: 2]);
      ctrl_r.wdPeriodSel     <= pwdata[PERIOD_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hardware refresh pin: two-stage synchroniser, then rising-edge detect
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      hwMeta_r <= 1'b0;
      hwSync_r <= 1'b0;
      hwDly_r  <= 1'b0;
    end
    else
    begin
      hwMeta_r <= hwRefresh;
      hwSync_r <= hwMeta_r;
      hwDly_r  <= hwSync_r;
    end
  end

  assign hwEdge = hwSync_r && !hwDly_r && !ctrl_r.wdRefreshSource;
  // Refresh bit is not key protected and never stored
  assign swRefreshHit = wrAccess && hitCtrl && pwdata[SW_REFR_BIT];
  assign refreshNow = hwEdge || (swRefreshHit && ctrl_r.wdRefreshSource);

  assign active = ctrl_r.wdRun && (!sleepState || ctrl_r.wdSleepRun);

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond prescaler; freezing it on pause keeps the period exact
  assign tick = (pre_r == 32'(TICK_CYCLES - 1));
  assign step = tick && !ctrl_r.wdPause;

  always_ff @(posedge clock)
  begin
    if (reset || !active || refreshNow)
      pre_r <= 32'h0;
    else if (!ctrl_r.wdPause)
      pre_r <= tick ? 32'h0 : pre_r + 32'h1;
  end

  assign periodTicks = 16'(BASE_TICKS) << ctrl_r.wdPeriodSel;
  assign expire = active && !refreshNow && step && (cnt_r == periodTicks - 16'h1)
                  && (state_r == ST_FIRST || state_r == ST_SECOND);

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 16'h0;
    end
    else if (!active || refreshNow)
    begin
      cnt_r   <= 16'h0;
      state_r <= active ? ST_FIRST : ST_IDLE;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          state_r <= ST_FIRST;
        ST_FIRST, ST_SECOND:
          if (expire)
          begin
            cnt_r   <= 16'h0;
            state_r <= (state_r == ST_FIRST) ? ST_SECOND : ST_DONE;
          end
          else if (step)
            cnt_r <= cnt_r + 16'h1;
        ST_DONE:
          state_r <= ST_DONE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  assign stateOut = state_r;

  ////////////////////////////////////////////////////////////////////////////
  function automatic swdt_act_t decodeAct(input swdt_action_t a);
    swdt_act_t r;
    r = '0;
    r.irq      = (a == ACT_IRQ);
    r.devReset = (a == ACT_RESET);
    r.wake     = (a == ACT_WAKE);
    return r;
  endfunction

  // Actions are one-cycle pulses; the system side latches what it needs
  always_ff @(posedge clock)
  begin
    if (reset || !expire)
      actOut <= '0;
    else if (state_r == ST_FIRST)
      actOut <= decodeAct(ctrl_r.wdFirstAction);
    else
      actOut <= decodeAct(ctrl_r.wdSecondAction);
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  property p_runNoRestart;
    $rose(ctrl_r.wdRun) && !refreshNow |=> cnt_r == 16'h0 && pre_r <= 32'h1;
  endproperty
  a_runNoRestart: assert property (p_runNoRestart)
    else $error("enable changed count");

  property p_pauseFreeze;
    active && ctrl_r.wdPause && !refreshNow && !$rose(ctrl_r.wdPause)
      ##1 active && !refreshNow |-> $stable(cnt_r) && $stable(pre_r);
  endproperty
  a_pauseFreeze: assert property (p_pauseFreeze)
    else $error("count moved while paused");

  property p_swRefreshIgnored;
    swRefreshHit && !ctrl_r.wdRefreshSource && !hwEdge && active && !expire && cnt_r != 16'h0
      |=> cnt_r != 16'h0;
  endproperty
  a_swRefreshIgnored: assert property (p_swRefreshIgnored)
    else $error("software refresh acted in hardware mode");

  property p_sleepStop;
    sleepState && !ctrl_r.wdSleepRun |=> state_r == ST_IDLE && actOut == '0;
  endproperty
  a_sleepStop: assert property (p_sleepStop)
    else $error("watchdog ran in sleep");

  property p_firstAction;
    expire && state_r == ST_FIRST |=> state_r == ST_SECOND
      && actOut == decodeAct($past(ctrl_r.wdFirstAction));
  endproperty
  a_firstAction: assert property (p_firstAction)
    else $error("first action wrong");

  property p_secondAction;
    expire && state_r == ST_SECOND |=> state_r == ST_DONE
      && actOut == decodeAct($past(ctrl_r.wdSecondAction)) ##1 actOut == '0;
  endproperty
  a_secondAction: assert property (p_secondAction)
    else $error("second action wrong");

  property p_lockedWrite;
    wrAccess && hitCtrl && !unlocked_r |=> $stable(ctrl_r);
  endproperty
  a_lockedWrite: assert property (p_lockedWrite)
    else $error("locked write changed control");

  property p_unlock;
    wrAccess && hitSecure |=> unlocked_r == ($past(pwdata[15:0]) == UNLOCK_KEY);
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("key handling wrong");

  property p_refreshRearm;
    refreshNow && active |=> state_r == ST_FIRST && cnt_r == 16'h0 && pre_r == 32'h0;
  endproperty
  a_refreshRearm: assert property (p_refreshRearm)
    else $error("refresh did not re-arm");

  property p_runKeepsCount;
    wrAccess && hitCtrl && unlocked_r && pwdata[RUN_BIT] && active && !refreshNow && !expire
      |=> cnt_r == $past(cnt_r) || cnt_r == $past(cnt_r) + 16'h1;
  endproperty
  a_runKeepsCount: assert property (p_runKeepsCount)
    else $error("run write disturbed count");

  property p_hwRefreshIgnored;
    hwSync_r && !hwDly_r && ctrl_r.wdRefreshSource && !swRefreshHit && active && !expire
      && cnt_r != 16'h0 |=> cnt_r != 16'h0;
  endproperty
  a_hwRefreshIgnored: assert property (p_hwRefreshIgnored)
    else $error("hardware refresh acted in software mode");

  property p_actionPulse;
    actOut != '0 |=> actOut == '0;
  endproperty
  a_actionPulse: assert property (p_actionPulse)
    else $error("action held longer than one cycle");

  property p_disableClear;
    !active |=> state_r == ST_IDLE && cnt_r == 16'h0 && pre_r == 32'h0;
  endproperty
  a_disableClear: assert property (p_disableClear)
    else $error("disabled watchdog kept its count");

  property p_sleepFollow;
    sleepState && ctrl_r.wdSleepRun && ctrl_r.wdRun && !refreshNow
      && state_r == ST_IDLE |=> state_r == ST_FIRST;
  endproperty
  a_sleepFollow: assert property (p_sleepFollow)
    else $error("sleep run did not follow run bit");

  property p_swRefresh;
    swRefreshHit && ctrl_r.wdRefreshSource && active
      |=> state_r == ST_FIRST && cnt_r == 16'h0;
  endproperty
  a_swRefresh: assert property (p_swRefresh)
    else $error("software refresh ignored in software mode");

endmodule

//--- system_watchdog_timer_tb.sv
// Self-checking testbench of the system watchdog timer
module system_watchdog_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import swdt_pkg::*;
  localparam int TK  = 2;
  localparam int PER = BASE_TICKS * TK;
  logic        clock;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hwRefresh;
  logic        sleepState;
  swdt_act_t   actOut;
  swdt_state_t stateOut;
  int          errors = 0;
  int          compares = 0;
  int          n;
  logic [2:0]  s;

  swdt_top #(.TICK_CYCLES(TK)) i_swdt_top (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hwRefresh(hwRefresh), .sleepState(sleepState),
    .actOut(actOut), .stateOut(stateOut));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen at a rising edge
  task apb(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q,
           output logic e);
    int k;
    k = 0;
    // Launch on an edge even when called from a sampling point
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      errors++;
      complete_run;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task rdc(input logic [15:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    cmp(q, exp);
    cmp({31'h0, e}, {31'h0, experr});
  endtask

  function automatic logic [31:0] cfg(input logic run, input logic pau, input logic src,
    input logic slp, input logic [1:0] sec, input logic [1:0] fst, input logic [2:0] per);
    return {16'h0, run, pau, src, slp, 2'h0, sec, 2'h0, fst, 1'b0, per};
  endfunction

  function automatic logic [2:0] act(input logic [1:0] c);
    return {c == 2'h1, c == 2'h2, c == 2'h3};
  endfunction

  // Counts edges until the state is reached, collecting action pulses
  task wst(input swdt_state_t t, input int mx);
    n = 0;
    s = 3'h0;
    while (stateOut !== t && n < mx)
    begin
      @(posedge clock);
      #1;
      n++;
      s |= actOut;
    end
    if (stateOut !== t)
    begin
      errors++;
      complete_run;
    end
    repeat (2)
    begin
      @(posedge clock);
      #1;
      s |= actOut;
    end
  endtask

  task pulse_hw;
    @(posedge clock);
    hwRefresh <= 1'b1;
    repeat (2) @(posedge clock);
    hwRefresh <= 1'b0;
    repeat (8) @(posedge clock);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_reset_lock;
    cmp(stateOut, ST_FIRST);
    rdc(CTRL_OFFSET, {16'h0, CTRL_RESET}, 1'b0);
    rdc(16'h4000, 32'h0, 1'b1);
    wr(CTRL_OFFSET, 32'h0);
    rdc(CTRL_OFFSET, {16'h0, CTRL_RESET}, 1'b0);
    wr(SECURE_OFFSET, {16'h0, UNLOCK_KEY});
    rdc(SECURE_OFFSET, 32'h1, 1'b0);
  endtask

  // Every action code on both stages, two period codes
  task t_actions;
    for (int c = 0; c < 4; c++)
    begin
      wr(CTRL_OFFSET, cfg(1, 0, 1, 0, 2'(3 - c), 2'(c), 3'(c % 2)) | 32'h800);
      wst(ST_SECOND, 4 * PER);
      cmp(s, act(2'(c)));
      wst(ST_DONE, 4 * PER);
      cmp(n, (PER << (c % 2)) - 2);
      cmp(s, act(2'(3 - c)));
    end
  endtask

  task t_pause_run;
    wr(CTRL_OFFSET, cfg(1, 0, 1, 0, 0, 1, 0) | 32'h800);
    wr(CTRL_OFFSET, cfg(1, 1, 1, 0, 0, 1, 0));
    repeat (PER + 20) @(posedge clock);
    #1 cmp(stateOut, ST_FIRST);
    wr(CTRL_OFFSET, cfg(1, 0, 1, 0, 0, 1, 0));
    wst(ST_SECOND, PER);
    cmp(s, 3'h4);
    wr(CTRL_OFFSET, cfg(0, 0, 1, 0, 0, 1, 0));
    repeat (PER + 20) @(posedge clock);
    #1 cmp(stateOut, ST_IDLE);
    wr(CTRL_OFFSET, cfg(1, 0, 1, 0, 0, 1, 0));
    wst(ST_SECOND, 2 * PER);
    cmp(n > PER - 8, 1);
  endtask

  task t_source_sleep;
    wr(CTRL_OFFSET, cfg(1, 0, 0, 0, 0, 1, 0));
    pulse_hw;
    repeat (PER / 2) @(posedge clock);
    wr(CTRL_OFFSET, cfg(1, 0, 0, 0, 0, 1, 0) | 32'h800);
    wst(ST_SECOND, PER);
    cmp(n < PER * 3 / 4, 1);
    pulse_hw;
    cmp(stateOut, ST_FIRST);
    wr(CTRL_OFFSET, cfg(1, 0, 1, 0, 0, 1, 0));
    wst(ST_SECOND, 2 * PER);
    pulse_hw;
    cmp(stateOut, ST_SECOND);
    @(posedge clock);
    sleepState <= 1'b1;
    repeat (3) @(posedge clock);
    #1 cmp(stateOut, ST_IDLE);
    wr(CTRL_OFFSET, cfg(1, 0, 1, 1, 0, 1, 0));
    #1 cmp(stateOut, ST_FIRST);
    @(posedge clock);
    sleepState <= 1'b0;
  endtask

  // Locked key still lets the refresh bit through, nothing else
  task t_locked_refresh;
    wr(SECURE_OFFSET, 32'h0);
    rdc(SECURE_OFFSET, 32'h0, 1'b0);
    repeat (PER / 2) @(posedge clock);
    wr(CTRL_OFFSET, 32'h800);
    wst(ST_SECOND, PER);
    cmp(n > PER - 8, 1);
    rdc(CTRL_OFFSET, cfg(1, 0, 1, 1, 0, 1, 0), 1'b0);
  endtask

  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    hwRefresh = 1'b0;
    sleepState = 1'b0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    t_reset_lock;
    t_actions;
    t_pause_run;
    t_source_sleep;
    t_locked_refresh;
    complete_run;
  end
endmodule
